// ### rtl/power_accum_pkg.sv
// Purpose: Shared constants and carriers for the power accumulation and pulse sign block.
// Assumes: One 100 MHz clock; samples arrive as single-cycle strobes at the 4 kSPS rate.
// Notes: Register bits are plain ports because the block has no bus of its own.
`default_nettype none
package power_accum_pkg;
    // Sample, accumulator, interval and divisor widths, accumulator shift, and phase and pulse output counts.
    localparam int SAMPLE_W = 32;
    localparam int ACC_W = 45;
    localparam int ACC_SHIFT = 13;
    localparam int INTERVAL_W = 13;
    localparam int DIVISOR_W = 16;
    localparam int NUM_PHASES = 3;
    localparam int NUM_PULSE = 4;
    // Reset values.
    localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 13'h0000;
    localparam logic [DIVISOR_W-1:0] DIVISOR_RESET = 16'hFFFF;
    // Interval timing in microseconds per sample, and the documented range limits.
    localparam int SAMPLE_PERIOD_US = 250;
    localparam int MIN_INTERVAL_US = 500;
    localparam int MAX_INTERVAL_US = 2048000;

    // One sample set for all three phases.
    typedef struct packed {
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] active;
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] reactive;
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] fundReactive;
    } sample_set_s;

    // Published sums for all three phases.
    typedef struct packed {
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] active;
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] reactive;
        logic [NUM_PHASES-1:0][SAMPLE_W-1:0] fundReactive;
    } power_regs_s;
endpackage
`default_nettype wire

// ### rtl/pulse_sign_ctrl.sv
// Purpose: Divides converter pulses, tracks pulse polarity and handles clear and disable.
// Assumes: Converter pulses carry the sign of the energy that produced them.
// Notes: One instance serves one pulse output.
`default_nettype none
module pulse_sign_ctrl
    import power_accum_pkg::*;
#(
    parameter int DW = DIVISOR_W
) (
    input wire logic core_clk,
    input wire logic rstSyncN,
    input wire logic dtofPulse,
    input wire logic dtofNeg,
    input wire logic [DW-1:0] divisor,
    input wire logic accClear,
    input wire logic outDisable,
    output logic pulseOutN,
    output logic energySign,
    output logic polarityFlip,
    output logic pulseReady
);
    typedef struct packed {
        logic [DW-1:0] count;
        logic negSum;
        logic outN;
        logic sign;
        logic flip;
        logic ready;
        logic seen;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    logic [DW-1:0] lastCount;
    logic emit;

    assign lastCount = divisor - DW'(1);
    assign emit = dtofPulse && !accClear && (cur_ff.count >= lastCount);

    // ------------------------------------------------------------------
    // Divider and polarity logic
    // ------------------------------------------------------------------
    // Counts converter pulses and records the sign of each finished pulse.
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.flip = 1'b0;
        nxt_cur.ready = 1'b0;
        nxt_cur.outN = 1'b1;
        if (accClear) begin
            nxt_cur.count = '0;
            nxt_cur.negSum = 1'b0;
        end else if (dtofPulse) begin
            if (emit) begin
                nxt_cur.count = '0;
                nxt_cur.negSum = 1'b0;
                nxt_cur.sign = cur_ff.negSum ^ dtofNeg;
                nxt_cur.seen = 1'b1;
                nxt_cur.flip = cur_ff.seen && (cur_ff.sign != (cur_ff.negSum ^ dtofNeg));
                nxt_cur.outN = outDisable;
                nxt_cur.ready = !outDisable;
            end else begin
                nxt_cur.count = cur_ff.count + DW'(1);
                nxt_cur.negSum = cur_ff.negSum ^ dtofNeg;
            end
        end
    end

    // Registers the whole state.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cur_ff <= '{count: '0, negSum: 1'b0, outN: 1'b1, sign: 1'b0,
                        flip: 1'b0, ready: 1'b0, seen: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign pulseOutN = cur_ff.outN;
    assign energySign = cur_ff.sign;
    assign polarityFlip = cur_ff.flip;
    assign pulseReady = cur_ff.ready;

    // Disabled output never pulses.
    chk_disable_holds_high: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        $past(outDisable) |-> pulseOutN) else $error("Pulse seen while output disabled.");
    // Ready never raised when disabled.
    chk_disable_no_ready: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        $past(outDisable) |-> !pulseReady) else $error("Ready raised while disabled.");
    // Clear empties the counter next cycle.
    chk_clear_resets_count: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        accClear |=> cur_ff.count == '0) else $error("Clear left a partial count.");
    // Flip only when the sign changes.
    chk_flip_on_change: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        polarityFlip |-> energySign != $past(energySign)) else $error("Flip without sign change.");
endmodule
`default_nettype wire

// ### rtl/power_accum_sign_pulse_ctrl.sv
// Purpose: Accumulates per-phase power over an interval, tracks signs, runs pulse sign logic.
// Assumes: sampleValid pulses once per 4 kSPS sample; converter pulses come from outside.
// Notes: Sticky flags are cleared by write-one strobes; a set in the same cycle wins.
//
// Contract
// - Record sign of energy behind last pulse
// - Polarity change sets flip in both statuses
// - Clear drops partial pulse accumulation and divider
// - Clear control returns to zero by itself
// - Disabled output stops pulsing, stays high
// - Disabled output never sets pulse-ready
// - Flip flags ignore the disable bits
// - Accumulate samples, copy on power-ready
// - Power-ready after interval plus one samples
// - Interval field is 13 bits wide
// - User register is accumulator top 32 bits
// - Power accumulator width equals energy accumulator
// - Six sign-change flags in primary status
// - Select bit picks total or fundamental reactive
// - Phase sign register holds six signs
// - Signs update with the power registers
// - Split samples into positive and negative sums
// - Positive and negative sums restart each interval
// - Three phases combine into one sum pair
// - One pulse per divisor converter pulses
`default_nettype none
module power_accum_sign_pulse_ctrl
    import power_accum_pkg::*;
#(
    parameter int NP = NUM_PULSE
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sampleValid,
    input wire power_accum_pkg::sample_set_s samples,
    input wire logic [power_accum_pkg::INTERVAL_W-1:0] powerInterval,
    input wire logic signSourceSelect,
    input wire logic [NP-1:0] dtofPulse,
    input wire logic [NP-1:0] dtofNeg,
    input wire logic [NP-1:0][power_accum_pkg::DIVISOR_W-1:0] pulseDivisor,
    input wire logic [NP-1:0] pulseOutDisable,
    input wire logic pulseAccumClearWr,
    input wire logic [5:0] signFlipClear,
    input wire logic [NP-1:0] polarityFlipClear,
    input wire logic [NP-1:0] polarityEventClear,
    input wire logic [NP-1:0] pulseReadyClear,
    output power_accum_pkg::power_regs_s powerRegs,
    output logic [power_accum_pkg::SAMPLE_W-1:0] positiveActiveSum,
    output logic [power_accum_pkg::SAMPLE_W-1:0] negativeActiveSum,
    output logic [power_accum_pkg::SAMPLE_W-1:0] positiveReactiveSum,
    output logic [power_accum_pkg::SAMPLE_W-1:0] negativeReactiveSum,
    output logic powerReady,
    output logic [5:0] phaseSignReg,
    output logic [5:0] signFlipStatus,
    output logic [NP-1:0] pulseEnergySign,
    output logic [NP-1:0] pulsePolarityFlip,
    output logic [NP-1:0] pulsePolarityEvent,
    output logic [NP-1:0] pulseReadyStatus,
    output logic pulseAccumClear,
    output logic [NP-1:0] pulseOutN
);
    localparam int PH = NUM_PHASES;

    typedef struct packed {
        logic [1:0] rstSync;
        logic [INTERVAL_W-1:0] sampleCount;
        logic [PH-1:0][ACC_W-1:0] accActive;
        logic [PH-1:0][ACC_W-1:0] accReactive;
        logic [PH-1:0][ACC_W-1:0] accFund;
        logic [3:0][ACC_W-1:0] accSplit;
        power_regs_s regs;
        logic [3:0][SAMPLE_W-1:0] split;
        logic ready;
        logic [5:0] signs;
        logic [5:0] flips;
        logic [NP-1:0] pFlip;
        logic [NP-1:0] pEvent;
        logic [NP-1:0] pReady;
        logic clear;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    logic rstSyncN;
    logic [NP-1:0] unitSign;
    logic [NP-1:0] unitFlip;
    logic [NP-1:0] unitReady;
    logic [NP-1:0] unitOutN;
    logic [NP-1:0] outN_ff;

    // Sign extends one sample to accumulator width.
    function automatic logic [ACC_W-1:0] widen(input logic [SAMPLE_W-1:0] s);
        widen = {{(ACC_W-SAMPLE_W){s[SAMPLE_W-1]}}, s};
    endfunction

    // Magnitude of a negative sample, zero for a non-negative one.
    function automatic logic [ACC_W-1:0] negPart(input logic [SAMPLE_W-1:0] s);
        negPart = s[SAMPLE_W-1] ? ACC_W'(-widen(s)) : '0;
    endfunction

    // Value of a non-negative sample, zero for a negative one.
    function automatic logic [ACC_W-1:0] posPart(input logic [SAMPLE_W-1:0] s);
        posPart = s[SAMPLE_W-1] ? '0 : widen(s);
    endfunction

    // Top 32 bits of an accumulator, an arithmetic shift that rounds down.
    function automatic logic [SAMPLE_W-1:0] topBits(input logic [ACC_W-1:0] a);
        topBits = a[ACC_W-1:ACC_SHIFT];
    endfunction

    assign rstSyncN = cur_ff.rstSync[1];

    // ------------------------------------------------------------------
    // Pulse outputs
    // ------------------------------------------------------------------
    // One divider and sign tracker per pulse output.
    for (genvar k = 0; k < NP; k++) begin : g_pulse
        pulse_sign_ctrl #(
            .DW(DIVISOR_W)
        ) u_pulse (
            .core_clk(core_clk),
            .rstSyncN(rstSyncN),
            .dtofPulse(dtofPulse[k]),
            .dtofNeg(dtofNeg[k]),
            .divisor(pulseDivisor[k]),
            .accClear(cur_ff.clear),
            .outDisable(pulseOutDisable[k]),
            .pulseOutN(unitOutN[k]),
            .energySign(unitSign[k]),
            .polarityFlip(unitFlip[k]),
            .pulseReady(unitReady[k])
        );
    end

    // ------------------------------------------------------------------
    // Accumulation and status
    // ------------------------------------------------------------------
    // Computes the next state of the accumulators and status flags.
    always_comb begin
        logic endOfInterval;
        logic [ACC_W-1:0] reactSel;
        endOfInterval = 1'b0;
        reactSel = '0;
        nxt_cur = cur_ff;
        nxt_cur.rstSync = {cur_ff.rstSync[0], 1'b1};
        nxt_cur.ready = 1'b0;
        nxt_cur.clear = pulseAccumClearWr;
        if (sampleValid) begin
            endOfInterval = (cur_ff.sampleCount == powerInterval);
            nxt_cur.sampleCount = endOfInterval ? '0 : cur_ff.sampleCount + INTERVAL_W'(1);
            for (int p = 0; p < PH; p++) begin
                nxt_cur.accActive[p] = cur_ff.accActive[p] + widen(samples.active[p]);
                nxt_cur.accReactive[p] = cur_ff.accReactive[p] + widen(samples.reactive[p]);
                nxt_cur.accFund[p] = cur_ff.accFund[p] + widen(samples.fundReactive[p]);
                nxt_cur.accSplit[0] = nxt_cur.accSplit[0] + posPart(samples.active[p]);
                nxt_cur.accSplit[1] = nxt_cur.accSplit[1] + negPart(samples.active[p]);
                nxt_cur.accSplit[2] = nxt_cur.accSplit[2] + posPart(samples.reactive[p]);
                nxt_cur.accSplit[3] = nxt_cur.accSplit[3] + negPart(samples.reactive[p]);
            end
            if (endOfInterval) begin
                nxt_cur.ready = 1'b1;
                for (int p = 0; p < PH; p++) begin
                    nxt_cur.regs.active[p] = topBits(nxt_cur.accActive[p]);
                    nxt_cur.regs.reactive[p] = topBits(nxt_cur.accReactive[p]);
                    nxt_cur.regs.fundReactive[p] = topBits(nxt_cur.accFund[p]);
                    reactSel = signSourceSelect ? nxt_cur.accFund[p] : nxt_cur.accReactive[p];
                    nxt_cur.signs[2*p] = nxt_cur.accActive[p][ACC_W-1];
                    nxt_cur.signs[2*p+1] = reactSel[ACC_W-1];
                    nxt_cur.accActive[p] = '0;
                    nxt_cur.accReactive[p] = '0;
                    nxt_cur.accFund[p] = '0;
                end
                for (int q = 0; q < 4; q++) begin
                    nxt_cur.split[q] = topBits(nxt_cur.accSplit[q]);
                    nxt_cur.accSplit[q] = '0;
                end
            end
        end
        nxt_cur.flips = (cur_ff.flips & ~signFlipClear)
            | (nxt_cur.ready ? (nxt_cur.signs ^ cur_ff.signs) : 6'h00);
        nxt_cur.pFlip = (cur_ff.pFlip & ~polarityFlipClear) | unitFlip;
        nxt_cur.pEvent = (cur_ff.pEvent & ~polarityEventClear) | unitFlip;
        nxt_cur.pReady = (cur_ff.pReady & ~pulseReadyClear) | unitReady;
    end

    // Registers the whole state; the reset synchroniser takes the raw reset.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Registers the pin levels so every output leaves a flip-flop.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            outN_ff <= '1;
        end else begin
            outN_ff <= unitOutN;
        end
    end

    assign powerRegs = cur_ff.regs;
    assign positiveActiveSum = cur_ff.split[0];
    assign negativeActiveSum = cur_ff.split[1];
    assign positiveReactiveSum = cur_ff.split[2];
    assign negativeReactiveSum = cur_ff.split[3];
    assign powerReady = cur_ff.ready;
    assign phaseSignReg = cur_ff.signs;
    assign signFlipStatus = cur_ff.flips;
    assign pulseEnergySign = unitSign;
    assign pulsePolarityFlip = cur_ff.pFlip;
    assign pulsePolarityEvent = cur_ff.pEvent;
    assign pulseReadyStatus = cur_ff.pReady;
    assign pulseAccumClear = cur_ff.clear;
    assign pulseOutN = outN_ff;

    // Ready only on a sample that closes the interval.
    chk_ready_interval: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        powerReady |-> $past(sampleValid) && $past(cur_ff.sampleCount) == $past(powerInterval))
        else $error("Power ready outside interval end.");
    // Clear bit falls the cycle after the write strobe is gone.
    chk_clear_self: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        pulseAccumClear && !pulseAccumClearWr |=> !pulseAccumClear)
        else $error("Clear control did not return to zero.");
    // Phase sign matches the published register.
    chk_sign_match: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        powerReady |-> phaseSignReg[0] == powerRegs.active[0][SAMPLE_W-1])
        else $error("Active sign disagrees with register.");
    // Flag stays set until cleared.
    chk_flip_sticky: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        signFlipStatus[0] && !signFlipClear[0] |=> signFlipStatus[0])
        else $error("Sign-change flag dropped without clear.");
    // Sign changes never pass unflagged.
    chk_flip_set: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        powerReady && phaseSignReg != $past(phaseSignReg) |-> signFlipStatus != 6'h00)
        else $error("Sign change not flagged.");
    // Split sums clear after the interval.
    chk_split_restart: assert property (@(posedge core_clk) disable iff (!rstSyncN)
        powerReady |-> cur_ff.accSplit[0] == '0) else $error("Split sum not restarted.");
endmodule
`default_nettype wire

// ### testbench/host_reader.sv
// Purpose: Host side reader that copies the power registers on each ready pulse.
// Assumes: powerReady is a one-cycle pulse launched by the block.
// Notes: The copy is taken the way a host would take it after its ready event.
`default_nettype none
module host_reader
    import power_accum_pkg::*;
(
    input wire logic core_clk,
    input wire power_accum_pkg::power_regs_s powerRegs,
    input wire logic powerReady,
    output power_accum_pkg::power_regs_s snapFf
);
    timeunit 1ns;
    timeprecision 1ps;
    // Take a copy of all power register sums on each ready pulse; the copy holds until the next ready pulse.
    always @(posedge core_clk) begin
        if (powerReady) begin
            snapFf <= powerRegs;
        end
    end
endmodule
`default_nettype wire

// ### testbench/power_accum_sign_pulse_ctrl_tb.sv
// Purpose: Self-checking bench for the power accumulation and pulse sign block.
// Assumes: Samples and converter pulses come closer together than in the device.
// Notes: Expected sums and signs are worked out here from the sample values.
`default_nettype none
module power_accum_sign_pulse_ctrl_tb
    import power_accum_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus, observation and bookkeeping
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic sampleValid = 1'b0;
    sample_set_s samples = '0;
    logic [INTERVAL_W-1:0] powerInterval = '0;
    logic signSourceSelect = 1'b0;
    logic [NUM_PULSE-1:0] dtofPulse = '0;
    logic [NUM_PULSE-1:0] dtofNeg = '0;
    logic [NUM_PULSE-1:0][DIVISOR_W-1:0] pulseDivisor = {16'hFFFF, 16'hFFFF, 16'h0002, 16'h0003};
    logic [NUM_PULSE-1:0] pulseOutDisable = '0;
    logic pulseAccumClearWr = 1'b0;
    logic [5:0] signFlipClear = '0;
    logic [NUM_PULSE-1:0] polarityFlipClear = '0;
    logic [NUM_PULSE-1:0] polarityEventClear = '0;
    logic [NUM_PULSE-1:0] pulseReadyClear = '0;
    power_regs_s powerRegs;
    power_regs_s snap;
    logic [31:0] positiveActiveSum, negativeActiveSum, positiveReactiveSum, negativeReactiveSum;
    logic powerReady, pulseAccumClear;
    logic [5:0] phaseSignReg, signFlipStatus;
    logic [NUM_PULSE-1:0] pulseEnergySign, pulsePolarityFlip, pulsePolarityEvent;
    logic [NUM_PULSE-1:0] pulseReadyStatus, pulseOutN;
    int errTotal = 0;
    int samplesChecked = 0;
    logic signed [31:0] actV [3] = '{32'sh0100_0000, 32'shFFF0_0000, 32'sh0000_1388};
    logic signed [31:0] reaV [3] = '{32'shFFFB_6C20, 32'sh0000_1B58, 32'sh0000_0000};
    logic signed [31:0] fndV [3] = '{32'sh0004_93E0, 32'shFFFF_E4A8, 32'sh0000_0001};

    power_accum_sign_pulse_ctrl dut (.core_clk(core_clk), .resetn(resetn),
        .sampleValid(sampleValid), .samples(samples), .powerInterval(powerInterval),
        .signSourceSelect(signSourceSelect), .dtofPulse(dtofPulse), .dtofNeg(dtofNeg),
        .pulseDivisor(pulseDivisor), .pulseOutDisable(pulseOutDisable),
        .pulseAccumClearWr(pulseAccumClearWr), .signFlipClear(signFlipClear),
        .polarityFlipClear(polarityFlipClear), .polarityEventClear(polarityEventClear),
        .pulseReadyClear(pulseReadyClear), .powerRegs(powerRegs),
        .positiveActiveSum(positiveActiveSum), .negativeActiveSum(negativeActiveSum),
        .positiveReactiveSum(positiveReactiveSum), .negativeReactiveSum(negativeReactiveSum),
        .powerReady(powerReady), .phaseSignReg(phaseSignReg), .signFlipStatus(signFlipStatus),
        .pulseEnergySign(pulseEnergySign), .pulsePolarityFlip(pulsePolarityFlip),
        .pulsePolarityEvent(pulsePolarityEvent), .pulseReadyStatus(pulseReadyStatus),
        .pulseAccumClear(pulseAccumClear), .pulseOutN(pulseOutN));
    host_reader host (.core_clk(core_clk), .powerRegs(powerRegs), .powerReady(powerReady),
        .snapFf(snap));

    // Compare one value and count it; an unknown never matches.
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask
    // Wait for edges, then step past them so their updates have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Top 32 of a 45-bit sum of n equal samples, rounded toward minus infinity.
    function automatic logic [31:0] scaled(input longint v, input int n);
        longint t;
        t = (v * n) >>> 13;
        return t[31:0];
    endfunction
    // Sign vector in the phase sign layout: bit 2p active, bit 2p+1 reactive.
    function automatic logic [5:0] signs(input logic sel);
        logic [5:0] s;
        for (int p = 0; p < 3; p++) begin
            s[2*p] = actV[p][31];
            s[2*p+1] = sel ? fndV[p][31] : reaV[p][31];
        end
        return s;
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Run one interval of n equal samples and judge every published sum.
    task automatic runInterval(input logic sel, input int n);
        longint pa, na, pr, nr;
        @(posedge core_clk);
        signSourceSelect <= sel;
        powerInterval <= 13'(n - 1);
        for (int p = 0; p < 3; p++) begin
            samples.active[p] <= actV[p];
            samples.reactive[p] <= reaV[p];
            samples.fundReactive[p] <= fndV[p];
        end
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            sampleValid <= 1'b1;
            @(posedge core_clk);
            sampleValid <= 1'b0;
            // The ready pulse stands only in the cycle after the closing sample.
            #1;
            chk("powerReady", 64'(powerReady), 64'(i == n - 1));
        end
        tick(1);
        chk("powerReady", 64'(powerReady), 64'h0);
        pa = 0; na = 0; pr = 0; nr = 0;
        for (int p = 0; p < 3; p++) begin
            chk("active", 64'(snap.active[p]), 64'(scaled(actV[p], n)));
            chk("reactive", 64'(snap.reactive[p]), 64'(scaled(reaV[p], n)));
            chk("fundReactive", 64'(snap.fundReactive[p]), 64'(scaled(fndV[p], n)));
            if (actV[p] < 0) na -= actV[p]; else pa += actV[p];
            if (reaV[p] < 0) nr -= reaV[p]; else pr += reaV[p];
        end
        chk("positiveActiveSum", 64'(positiveActiveSum), 64'(scaled(pa, n)));
        chk("negativeActiveSum", 64'(negativeActiveSum), 64'(scaled(na, n)));
        chk("positiveReactiveSum", 64'(positiveReactiveSum), 64'(scaled(pr, n)));
        chk("negativeReactiveSum", 64'(negativeReactiveSum), 64'(scaled(nr, n)));
        chk("phaseSignReg", 64'(phaseSignReg), 64'(signs(sel)));
    endtask
    // Power sums, signs and sticky sign-change flags over three intervals.
    task automatic testPower();
        runInterval(1'b0, 4);
        @(posedge core_clk);
        signFlipClear <= 6'h3F;
        @(posedge core_clk);
        signFlipClear <= 6'h00;
        tick(1);
        chk("signFlipStatus", 64'(signFlipStatus), 64'h0);
        runInterval(1'b1, 4);
        chk("signFlipStatus", 64'(signFlipStatus), 64'(signs(1'b0) ^ signs(1'b1)));
        runInterval(1'b1, 1);
        chk("signFlipStatus", 64'(signFlipStatus), 64'(signs(1'b0) ^ signs(1'b1)));
        $display("test power done");
    endtask
    // Send n converter pulses to output k, with signs taken from negs.
    task automatic burst(input int k, input int n, input logic [7:0] negs);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            dtofPulse[k] <= 1'b1;
            dtofNeg[k] <= negs[i];
            @(posedge core_clk);
            dtofPulse[k] <= 1'b0;
        end
    endtask
    // Watch the pin after the first and second edges that follow the last converter pulse.
    task automatic watch(input int k, input logic fire);
        tick(1);
        chk("pulseOutN", 64'(pulseOutN[k]), 64'(!fire));
        tick(1);
        chk("pulseOutN", 64'(pulseOutN[k]), 64'h1);
    endtask
    // Pulse sign, polarity change and write-one clearing of the pulse flags.
    task automatic testPulse();
        burst(0, 3, 8'h07);
        watch(0, 1'b1);
        chk("pulseEnergySign", 64'(pulseEnergySign[0]), 64'h1);
        chk("pulseReadyStatus", 64'(pulseReadyStatus[0]), 64'h1);
        chk("pulsePolarityFlip", 64'(pulsePolarityFlip[0]), 64'h0);
        burst(0, 3, 8'h00);
        watch(0, 1'b1);
        chk("pulseEnergySign", 64'(pulseEnergySign[0]), 64'h0);
        chk("flip and event", 64'({pulsePolarityFlip[0], pulsePolarityEvent[0]}), 64'h3);
        @(posedge core_clk);
        polarityFlipClear <= 4'hF;
        polarityEventClear <= 4'hF;
        pulseReadyClear <= 4'hF;
        @(posedge core_clk);
        polarityFlipClear <= 4'h0;
        polarityEventClear <= 4'h0;
        pulseReadyClear <= 4'h0;
        tick(1);
        chk("pulse flags", 64'({pulsePolarityFlip, pulsePolarityEvent, pulseReadyStatus}), 64'h0);
        $display("test pulse done");
    endtask
    // A partial count of two is dropped by the clear, so two more do not fire.
    task automatic testClear();
        burst(0, 2, 8'h00);
        @(posedge core_clk);
        pulseAccumClearWr <= 1'b1;
        @(posedge core_clk);
        pulseAccumClearWr <= 1'b0;
        #1;
        chk("pulseAccumClear", 64'(pulseAccumClear), 64'h1);
        tick(1);
        chk("pulseAccumClear", 64'(pulseAccumClear), 64'h0);
        tick(1);
        burst(0, 2, 8'h00);
        watch(0, 1'b0);
        burst(0, 1, 8'h00);
        watch(0, 1'b1);
        $display("test clear done");
    endtask
    // A disabled output stays high and sets no ready flag, yet tracks polarity.
    task automatic testDisable();
        @(posedge core_clk);
        pulseOutDisable <= 4'h2;
        burst(1, 2, 8'h01);
        watch(1, 1'b0);
        chk("pulseReadyStatus", 64'(pulseReadyStatus[1]), 64'h0);
        chk("pulseEnergySign", 64'(pulseEnergySign[1]), 64'h1);
        burst(1, 2, 8'h00);
        watch(1, 1'b0);
        chk("pulsePolarityFlip", 64'(pulsePolarityFlip[1]), 64'h1);
        @(posedge core_clk);
        pulseOutDisable <= 4'h0;
        burst(1, 2, 8'h00);
        watch(1, 1'b1);
        $display("test disable done");
    endtask
    // ----------------------------------------
    // Clock, sequence, watchdog and verdict
    // ----------------------------------------
    // Print the counts and the verdict, then end the run.
    task automatic stopTest();
        $display("comparisons %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Free-running 100 MHz clock.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // Reset for 20 cycles, let the synchroniser release, then run every scenario.
    initial begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        tick(3);
        chk("pulseOutN", 64'(pulseOutN), 64'hF);
        testPower();
        testPulse();
        testClear();
        testDisable();
        stopTest();
    end
    // The scenarios take well under a thousand cycles; a hang ends here.
    initial begin
        repeat (5000) @(posedge core_clk);
        errTotal++;
        $display("watchdog expired");
        stopTest();
    end
endmodule
`default_nettype wire
